// [sac_cmp_model.sv]
// comparator stand-in at the far side of the converter control block.
// assumes the bench gives the input level as a 10-bit fraction of the
// selected reference, so an ideal conversion returns exactly that level.
`timescale 1ns/100ps
module sac_cmp_model
  import sac_pkg::*;
(
  // clock
  input  wire logic        clk,
  // analog side
  input  wire sac_analog_s ana,
  input  wire logic [9:0]  dac_code,
  input  wire logic [9:0]  level,
  input  wire logic        slow,
  // decision
  output      logic        cmp_decision
);
  logic now_dec;
  logic late_dec;
  logic idle_pat = 1'b0;

  // ====================================================================
  // ideal decision: code zero at ground, full scale at the reference
  assign now_dec = (level >= dac_code);

  // slow mode answers a clock late, still well inside one converter clock
  always_ff @(posedge clk) begin
    late_dec <= now_dec;
    idle_pat <= ~idle_pat;
  end

  // powered down the comparator gives no decision, so the line wanders
  assign cmp_decision = !ana.power_on ? idle_pat :
                        (slow ? late_dec : now_dec);
endmodule : sac_cmp_model

// [sac_ctrl.sv]
// converter control: register port, prescaler, sequencer, result pair with
// read-order lock, and the digital input-off masks for the analog pins.
// assumes strobes synchronous to clk and a comparator answer that is valid
// one converter clock after the trial code changes.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "sac_regs.svh"

module sac_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register port
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output      logic [7:0]        rdata,
  // pads: bits 2:0 ch0-2, 3 ref pin, 7:4 ch3-6, 11:8 ch7-10
  input  wire logic [11:0]       pin_in,
  output      logic [11:0]       input_buf_off,
  // analog macro
  input  wire logic              cmp_decision,
  output      logic [9:0]        dac_code,
  output      sac_analog_s       ana
);

  // ========================================================================
  // storage
  logic [7:0]  dis_lo;
  logic [3:0]  dis_hi;
  logic        enable;
  logic [2:0]  prescale;
  logic        done_flag;
  logic        gain_sel;
  logic [2:0]  ref_sel;
  logic        adjust;
  logic [5:0]  channel;
  sac_state_e  state;
  logic        first_conv;
  logic [4:0]  cyc;
  logic [6:0]  presc;
  logic [9:0]  mask;
  logic [9:0]  result;
  logic        lock;
  logic [11:0] pin_val;

  // ========================================================================
  // decode
  logic        wr_dis_lo, wr_dis_hi, wr_ca, wr_cb, wr_is;
  logic        rd_res_lo, rd_res_hi;
  logic [6:0]  div_mask;
  logic        tick;
  logic [4:0]  conv_len;
  logic [4:0]  bit_start;
  logic        resolve;
  logic        conv_end;
  logic [11:0] off_mask;

  assign wr_dis_lo = wr && addr == `SAC_OFF_DIS_LO;
  assign wr_dis_hi = wr && addr == `SAC_OFF_DIS_HI;
  assign wr_ca     = wr && addr == `SAC_OFF_CTRL_A;
  assign wr_cb     = wr && addr == `SAC_OFF_CTRL_B;
  assign wr_is     = wr && addr == `SAC_OFF_IN_SEL;
  assign rd_res_lo = rd && addr == `SAC_OFF_RES_LO;
  assign rd_res_hi = rd && addr == `SAC_OFF_RES_HI;
  assign off_mask  = {dis_hi, dis_lo};

  // converter clock: one tick every 2^prescale system clocks, minimum 2
  assign div_mask  = (prescale < 3'd2) ? 7'h01
                   : 7'((8'h01 << prescale) - 8'h01);
  assign tick      = (presc & div_mask) == div_mask;

  // first conversion spends twelve extra clocks settling the analog side
  assign conv_len  = first_conv ? `SAC_LEN_FIRST : `SAC_LEN_NORMAL; // see RULE18
  assign bit_start = conv_len - `SAC_BITS_TAIL;
  assign resolve   = state == SAC_CONV && tick && cyc >= bit_start
                   && cyc < conv_len - 5'd1;
  assign conv_end  = state == SAC_CONV && tick && cyc == conv_len - 5'd1;

  // ========================================================================
  // input-off registers; high bits 3:0 do not exist
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dis_lo <= `SAC_RESET_BYTE;                      // see RULE22
      dis_hi <= 4'h0;
    end else begin
      if (wr_dis_lo) dis_lo <= wdata;                 // see RULE1
      if (wr_dis_hi) dis_hi <= wdata[7:4];            // see RULE3
    end
  end

  // masked pin sample and buffer-off controls; masked bits read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_val       <= 12'h000;
      input_buf_off <= 12'h000;
    end else begin
      pin_val       <= pin_in & ~off_mask;            // see RULE1 RULE2 RULE3
      input_buf_off <= off_mask;
    end
  end

  // ========================================================================
  // control registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable   <= 1'b0;
      prescale <= 3'h0;
      gain_sel <= 1'b0;
      ref_sel  <= 3'h0;
      adjust   <= 1'b0;
      channel  <= 6'h00;
    end else begin
      if (wr_ca) begin
        enable   <= wdata[`SAC_CA_ENABLE];
        prescale <= wdata[2:0];
      end
      // channel msb lives in control b, since bit 5 of input select is
      // already taken by the adjust bit
      if (wr_cb) begin
        gain_sel   <= wdata[`SAC_CB_GAIN];
        ref_sel[2] <= wdata[`SAC_CB_REF2];            // see RULE9
        channel[5] <= wdata[`SAC_CB_CHAN_HI];         // see RULE5
      end
      if (wr_is) begin
        ref_sel[1:0] <= wdata[`SAC_IS_REF_HI:`SAC_IS_REF_LO];
        adjust       <= wdata[`SAC_IS_ADJUST];
        channel[4:0] <= wdata[4:0];                   // see RULE5
      end
    end
  end

  // done flag: completion wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_flag <= 1'b0;
    end else if (conv_end) begin
      done_flag <= 1'b1;                              // see RULE16 RULE19
    end else if (wr_ca && wdata[`SAC_CA_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ========================================================================
  // prescaler, held at zero whenever the converter is off
  always_ff @(posedge clk) begin
    if (!reset_n || !enable) begin
      presc <= 7'h00;                                 // see RULE20
    end else begin
      presc <= presc + 7'h01;
    end
  end

  // ========================================================================
  // sequencer; clearing enable aborts any conversion in flight
  always_ff @(posedge clk) begin
    if (!reset_n || !enable) begin
      state      <= SAC_IDLE;
      first_conv <= 1'b1;
      cyc        <= 5'd0;
    end else begin
      unique case (state)
        SAC_IDLE: begin
          if (wr_ca && wdata[`SAC_CA_START]) state <= SAC_WAIT; // see RULE17
        end
        SAC_WAIT: begin
          // conversion starts on the next converter clock edge
          if (tick) begin
            state <= SAC_CONV;
            cyc   <= 5'd0;
          end
        end
        SAC_CONV: begin
          if (tick) begin
            cyc <= cyc + 5'd1;
            if (conv_end) begin
              state      <= SAC_IDLE;                 // see RULE17
              first_conv <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // successive approximation, msb first, one bit per converter clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dac_code <= 10'h000;
      mask     <= 10'h000;
    end else if (state == SAC_WAIT && tick) begin
      dac_code <= `SAC_SAR_TOP;
      mask     <= `SAC_SAR_TOP;
    end else if (resolve) begin
      // keep the trial bit only when the input is at or above it
      dac_code <= (cmp_decision ? dac_code : (dac_code & ~mask))
                | (mask >> 1);                        // see RULE21 RULE4
      mask     <= mask >> 1;
    end
  end

  // ========================================================================
  // result pair; a low byte read in the completion cycle also blocks it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result <= 10'h000;
    end else if (conv_end && !lock && !rd_res_lo) begin
      result <= dac_code;                             // see RULE19 RULE14
    end
  end

  // read-order lock keeps the two bytes from different conversions
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock <= 1'b0;
    end else if (rd_res_lo) begin
      lock <= 1'b1;                                   // see RULE14
    end else if (rd_res_hi) begin
      lock <= 1'b0;                                   // see RULE15
    end
  end

  // ========================================================================
  // analog path: selections only follow while enabled and not converting,
  // so a write during a conversion affects only the next one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // channel 0 is single-ended, so the gain stage starts bypassed
      ana <= '{gain_bypass: 1'b1, default: '0};
    end else begin
      ana.power_on <= enable;                         // see RULE11
      ana.sample   <= state == SAC_CONV && cyc < bit_start;
      if (enable && state != SAC_CONV) begin          // see RULE10
        ana.ref_sel     <= ref_sel;                   // see RULE9
        ana.channel     <= channel;                   // see RULE5 RULE7
        ana.gain_sel    <= gain_sel;                  // see RULE6
        ana.gain_bypass <= channel <= `SAC_CHAN_SE_LAST
                        || channel == `SAC_CHAN_TEMP;
        ana.temp_sel    <= channel == `SAC_CHAN_TEMP; // see RULE8
      end
    end
  end

  // ========================================================================
  // read data, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `SAC_OFF_PIN_LO: rdata <= pin_val[7:0];
        `SAC_OFF_PIN_HI: rdata <= {pin_val[11:8], 4'h0};
        `SAC_OFF_DIS_LO: rdata <= dis_lo;
        `SAC_OFF_DIS_HI: rdata <= {dis_hi, 4'h0};     // see RULE3
        `SAC_OFF_CTRL_A: rdata <= {enable, state != SAC_IDLE, 1'b0,
                                   done_flag, 1'b0, prescale};
        `SAC_OFF_CTRL_B: rdata <= {gain_sel, 2'b00, ref_sel[2], channel[5],
                                   3'h0};
        `SAC_OFF_IN_SEL: rdata <= {ref_sel[1:0], adjust, channel[4:0]};
        `SAC_OFF_RES_LO: rdata <= adjust ? {result[1:0], 6'h00}
                                         : result[7:0];   // see RULE12
        `SAC_OFF_RES_HI: rdata <= adjust ? result[9:2]
                                         : {6'h00, result[9:8]};
        default:         rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_lock_read;
    rd && addr == `SAC_OFF_RES_LO;
  endsequence

  sequence s_locked_end;
    lock && conv_end;
  endsequence

  AST_PIN_MASKED: assert property ( // see RULE1 RULE2
    rd && addr == `SAC_OFF_PIN_LO ##1 1'b1 |->
      (rdata & $past(dis_lo, 2)) == 8'h00)
    else $error("masked pin bit read as one");

  AST_HIGH_LOW_NIBBLE: assert property ( // see RULE3
    rd && addr == `SAC_OFF_DIS_HI |=> rdata[3:0] == 4'h0)
    else $error("read-only nibble of high input-off register not zero");

  AST_LOCK_DROPS: assert property ( // see RULE14
    s_locked_end or (s_lock_read ##0 conv_end) |=> $stable(result))
    else $error("locked result bytes were updated");

  // an unlocked completion without a low byte read in the same cycle must hand over the final trial code
  AST_STORE_RESULT: assert property ( // see RULE19
    conv_end && !lock && !rd_res_lo |=> result == $past(dac_code))
    else $error("finished result not stored");

  AST_UNLOCK: assert property ( // see RULE15
    rd && addr == `SAC_OFF_RES_HI |=> !lock)
    else $error("high byte read did not release lock");

  AST_DONE_SET: assert property ( // see RULE16 RULE19
    s_locked_end or (conv_end && !lock) |=> done_flag)
    else $error("done flag not set at end of conversion");

  AST_START_BUSY: assert property ( // see RULE17
    state == SAC_CONV && rd && addr == `SAC_OFF_CTRL_A |=>
      rdata[`SAC_CA_START])
    else $error("start bit not read as one during conversion");

  AST_CONV_LEN: assert property ( // see RULE18
    conv_end |-> cyc == (first_conv ? 5'd24 : 5'd12) && mask == 10'h000)
    else $error("conversion length or bit count wrong");

  AST_PRESC_HELD: assert property ( // see RULE20
    !enable ##1 !enable |-> presc == 7'h00 && state == SAC_IDLE)
    else $error("prescaler or sequencer ran while disabled");

  AST_POWER_OFF: assert property ( // see RULE11 RULE10
    !enable ##1 !enable |-> !ana.power_on && $stable(ana.channel))
    else $error("analog path powered or changed while disabled");

  AST_SAR_STEP: assert property ( // see RULE21
    resolve |=> mask == $past(mask) >> 1)
    else $error("sequencer skipped a bit");

  AST_BYPASS: assert property ( // see RULE6
    ana.channel <= `SAC_CHAN_SE_LAST |-> ana.gain_bypass)
    else $error("gain stage used on single-ended input");

  AST_TEMP_PICK: assert property ( // see RULE8
    ana.channel == `SAC_CHAN_TEMP |-> ana.temp_sel && ana.gain_bypass)
    else $error("temperature sensor not routed for its code");

  AST_RESET_CLEAR: assert property ( // see RULE22
    disable iff (1'b0) !reset_n |=> dis_lo == 8'h00 && dis_hi == 4'h0)
    else $error("input-off registers not cleared by reset");

endmodule : sac_ctrl

// [sac_pkg.sv]
// types shared by the converter control block.
// assumes sac_regs.svh supplies the numeric constants.
package sac_pkg;

  // ========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_WAIT,
    SAC_CONV
  } sac_state_e;

  // ========================================================================
  // selection and control presented to the analog macro
  typedef struct packed {
    logic       power_on;
    logic [2:0] ref_sel;
    logic [5:0] channel;
    logic       gain_sel;
    logic       gain_bypass;
    logic       temp_sel;
    logic       sample;
  } sac_analog_s;

endpackage : sac_pkg

// [sac_regs.svh]
// register map, field positions, reset values and timing counts of the
// converter control block.
// assumes byte-wide registers on a plain strobe port, one clock domain.
//
// Overview of operation
// RULE1: channel input-off bit set forces that pin's digital read to zero.
// RULE2: low register bit 3 forces the reference pin's digital read to zero.
// RULE3: high register bits 7:4 mask channels 10 to 7; bits 3:0 read zero.
// RULE4: conversion yields an unsigned 10-bit code, zero at ground.
// RULE5: six-bit channel field routes any of 11 single-ended pins.
// RULE6: differential picks use channel field plus gain bit; single-ended bypass.
// RULE7: same pin on both differential inputs is accepted, giving path offset.
// RULE8: channel code 111111 selects the temperature sensor.
// RULE9: three-bit reference field across two registers picks the reference.
// RULE10: selections reach the analog path only while the enable bit is one.
// RULE11: enable bit zero powers the converter down.
// RULE12: result right-aligned by default, left-aligned with the adjust bit.
// RULE13: software reads the low result byte before the high byte.
// RULE14: low byte read locks both result bytes; finished results are lost.
// RULE15: high byte read releases the lock.
// RULE16: done flag still sets when the result was dropped by the lock.
// RULE17: writing start begins a conversion; start reads one until done.
// RULE18: normal conversion lasts 13 converter clocks, first after enable 25.
// RULE19: on completion store result unless locked, and set the done flag.
// RULE20: prescaler counts while enabled and is held in reset otherwise.
// RULE21: sequencer resolves one bit per converter clock, msb first.
// RULE22: reset clears both input-off registers.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ==========================================================================
// register offsets
`define SAC_OFF_PIN_LO   8'h00
`define SAC_OFF_DIS_LO   8'h01
`define SAC_OFF_DIS_HI   8'h02
`define SAC_OFF_CTRL_A   8'h03
`define SAC_OFF_CTRL_B   8'h04
`define SAC_OFF_IN_SEL   8'h05
`define SAC_OFF_RES_LO   8'h06
`define SAC_OFF_RES_HI   8'h07
`define SAC_OFF_PIN_HI   8'h08

// ==========================================================================
// field positions and reset values
`define SAC_CA_ENABLE    7
`define SAC_CA_START     6
`define SAC_CA_DONE      4
`define SAC_CB_GAIN      7
`define SAC_CB_REF2      4
`define SAC_CB_CHAN_HI   3
`define SAC_IS_REF_HI    7
`define SAC_IS_REF_LO    6
`define SAC_IS_ADJUST    5
`define SAC_RESET_BYTE   8'h00
`define SAC_CHAN_TEMP    6'h3F
`define SAC_CHAN_SE_LAST 6'h0A
`define SAC_SAR_TOP      10'h200

// ==========================================================================
// timing in converter clocks
`define SAC_LEN_NORMAL   5'd13
`define SAC_LEN_FIRST    5'd25
`define SAC_BITS_TAIL    5'd11

`endif

// [tb_top.sv]
// self-checking bench for the converter control block.
// assumes the comparator model at the analog side and a prescale of 2.
`timescale 1ns/100ps
module tb_top
  import sac_pkg::*;
;
  localparam int P = 4; // clocks per converter clock, prescale field 2
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [11:0] pin_in;
  logic [11:0] input_buf_off;
  logic        cmp_decision;
  logic [9:0]  dac_code;
  sac_analog_s ana;
  logic [9:0]  level;
  logic        slow;
  logic [31:0] seed;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  // ====================================================================
  // design and far side
  sac_ctrl u_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
    .input_buf_off(input_buf_off), .cmp_decision(cmp_decision),
    .dac_code(dac_code), .ana(ana));
  sac_cmp_model u_cmp (.clk(clk), .ana(ana), .dac_code(dac_code),
    .level(level), .slow(slow), .cmp_decision(cmp_decision));

  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ====================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // start, poll the start bit, and bound the span by the tick count n
  task automatic conv(input int n);
    int t0;
    int k;
    logic [7:0] d;
    wr_reg(8'h03, 8'hC2);
    t0 = cyc;
    rd_reg(8'h03, d);
    chk(d[6], 1'b1);
    k = 0;
    while (d[6] !== 1'b0 && k < 300) begin
      rd_reg(8'h03, d);
      k++;
    end
    chk((cyc - t0 >= n * P) && (cyc - t0 <= (n + 2) * P), 1'b1);
  endtask : conv

  // right-aligned result pair, low byte first
  task automatic res_chk(input logic [9:0] r);
    logic [7:0] d;
    rd_reg(8'h06, d);
    chk(d, r[7:0]);
    rd_reg(8'h07, d);
    chk(d, {6'h00, r[9:8]});
  endtask : res_chk

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // ====================================================================
  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    results();
  end

  // ====================================================================
  // main sequence
  initial begin
    logic [7:0] d, lo, hi;
    logic [9:0] old;
    logic [2:0] r;
    logic [5:0] ch;
    logic       byp;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pin_in = 12'h000;
    level = 10'h000;
    slow = 1'b0;
    seed = 32'h6576;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd_reg(8'h01, d);
    chk(d, 8'h00);
    rd_reg(8'h02, d);
    chk(d, 8'h00);
    chk(input_buf_off, 12'h000);
    // input-off masks against random pads, corners first
    for (int i = 0; i < 8; i++) begin
      lo = (i == 0) ? 8'h08 : xs();
      hi = (i == 0) ? 8'hFF : xs();
      @(posedge clk);
      pin_in <= xs();
      wr_reg(8'h01, lo);
      wr_reg(8'h02, hi);
      rd_reg(8'h01, d);
      chk(d, lo);
      rd_reg(8'h02, d);
      chk(d, hi & 8'hF0);
      chk(input_buf_off, {hi[7:4], lo});
      rd_reg(8'h00, d);
      chk(d, pin_in[7:0] & ~lo);
      rd_reg(8'h08, d);
      chk(d, {pin_in[11:8] & ~hi[7:4], 4'h0});
    end
    // selections held back while disabled
    wr_reg(8'h05, 8'h05);
    repeat (2) @(posedge clk);
    chk(ana.power_on, 1'b0);
    chk(ana.channel, 6'h00);
    wr_reg(8'h40, 8'h00);
    wr_reg(8'h03, 8'h40);
    rd_reg(8'h03, d);
    chk(d[6], 1'b0);
    wr_reg(8'h03, 8'h82);
    for (int i = 0; i < 8; i++) begin
      r = i;
      ch = (i % 4 == 0) ? 6'h00 : (i % 4 == 1) ? 6'h0A :
           (i % 4 == 2) ? 6'h10 : 6'h3F;
      byp = (ch <= 6'h0A) || (ch == 6'h3F);
      wr_reg(8'h04, {r[0], 2'b00, r[2], ch[5], 3'h0});
      wr_reg(8'h05, {r[1:0], 1'b0, ch[4:0]});
      repeat (2) @(posedge clk);
      chk(ana.power_on, 1'b1);
      chk(ana.ref_sel, r);
      chk(ana.channel, ch);
      chk(ana.gain_bypass, byp);
      chk(ana.gain_sel & ~byp, r[0] & ~byp);
      chk(ana.temp_sel, ch == 6'h3F);
    end
    // first conversion, then both alignments read back
    wr_reg(8'h05, 8'h05);
    wr_reg(8'h03, 8'h00);
    wr_reg(8'h03, 8'h82);
    level <= xs();
    conv(25);
    rd_reg(8'h03, d);
    chk(d[4], 1'b1);
    res_chk(level);
    wr_reg(8'h05, 8'h25);
    rd_reg(8'h06, d);
    chk(d, {level[1:0], 6'h00});
    rd_reg(8'h07, d);
    chk(d, level[9:2]);
    wr_reg(8'h05, 8'h05);
    wr_reg(8'h03, 8'h92);
    rd_reg(8'h03, d);
    chk(d[4], 1'b0);
    // low read locks: the next result is lost but the flag still sets
    old = level;
    rd_reg(8'h06, d);
    level <= ~old;
    slow <= 1'b1;
    conv(13);
    rd_reg(8'h03, d);
    chk(d[4], 1'b1);
    rd_reg(8'h07, d);
    chk(d, {6'h00, old[9:8]});
    res_chk(old);
    conv(13);
    res_chk(level);
    // disable restarts the prescaler and the long first conversion
    wr_reg(8'h03, 8'h00);
    wr_reg(8'h03, 8'h82);
    conv(25);
    res_chk(level);
    // random levels with the end codes among them
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      level <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : xs();
      slow <= xs();
      conv(13);
      res_chk(level);
    end
    results();
  end
endmodule : tb_top
